// ---- rtl/pwm_pkg.sv ----
// Package: register map, field layout and carriers of the PWM block
package pwm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 4;
  localparam int NPAIR = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CLK_CONCAT = 8'h00;
  localparam logic [7:0] OFF_CLK_SEL_POL = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_SCALE0 = 8'h10;
  localparam logic [7:0] OFF_SCALE1 = 8'h14;
  localparam logic [7:0] OFF_GPIO_DIR = 8'h18;
  localparam logic [7:0] OFF_GPIO_DATA = 8'h1C;
  localparam logic [7:0] OFF_COUNTER = 8'h20;
  localparam logic [7:0] OFF_PERIOD = 8'h30;
  localparam logic [7:0] OFF_DUTY = 8'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CONCAT_UPPER = 7;
  localparam int BIT_CONCAT_LOWER = 6;
  localparam int POS_PRESCALE_A = 3;
  localparam int POS_PRESCALE_B = 0;
  localparam int POS_CLK_SEL = 4;
  localparam int POS_POLARITY = 0;
  localparam int BIT_CENTER = 0;

  // ----------------------------------------------------------------
  // Reset values and bus codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [6:0] RST_PRESCALE = 7'h00;
  localparam logic HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
  } pwm_aphase_s;

  typedef struct packed {
    logic concat;
    logic center;
  } pwm_pair_cfg_s;

endpackage

// ---- rtl/pwm_scaler.sv ----
// Scaled clock enable: divides a base tick by (scale + 1) and by two
`timescale 1ns/100ps
module pwm_scaler
  import pwm_pkg::*;
#(
  parameter int W = 8
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Base tick and scale
  input wire logic tick_in,
  input wire logic load,
  input wire logic [W-1:0] scale,
  // Scaled tick
  output logic tick_out
);

  logic [W-1:0] cnt_q;
  logic half_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      half_q <= 1'b0;
    end else if (load) begin
      cnt_q <= scale;
      half_q <= 1'b0;
    end else if (tick_in) begin
      if (cnt_q == '0) begin
        cnt_q <= scale;
        half_q <= ~half_q;
      end else begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end

  assign tick_out = tick_in & (cnt_q == '0) & half_q;

endmodule

// ---- rtl/pwm_pair.sv ----
// Two PWM channel counters that may run as one 16-bit channel
`timescale 1ns/100ps
module pwm_pair
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration, lane 0 is the high byte
  input wire pwm_pair_cfg_s cfg,
  input wire logic [1:0] enable,
  input wire logic [1:0] polarity,
  input wire logic [1:0] tick,
  input wire logic [1:0] clear,
  input wire logic [1:0][7:0] period,
  input wire logic [1:0][7:0] duty,
  // Status
  output logic [1:0][7:0] count,
  output logic [1:0] rollover,
  output logic [1:0] wave
);

  logic [1:0][7:0] cnt_q;
  logic [1:0] down_q;
  logic [1:0] wave_q;
  logic [1:0][17:0] nx;
  logic [17:0] nxp;

  // Next state as {rollover, down, count}
  function automatic logic [17:0] step(input logic [15:0] cnt,
                                       input logic [15:0] per,
                                       input logic down,
                                       input logic center);
    logic [17:0] r;
    r = {1'b0, down, cnt + 16'h0001};
    if (!center) begin
      if (cnt >= per) begin
        r = {2'b10, 16'h0000};
      end
    end else if (!down) begin
      if (cnt >= per) begin
        r = {2'b01, (cnt == 16'h0000) ? cnt : cnt - 16'h0001};
      end
    end else if (cnt == 16'h0000) begin
      r = {2'b10, (per == 16'h0000) ? cnt : cnt + 16'h0001};
    end else begin
      r = {2'b01, cnt - 16'h0001};
    end
    return r;
  endfunction

  // Output level for a count against duty
  function automatic logic level(input logic [15:0] cnt,
                                 input logic [15:0] dty,
                                 input logic [15:0] maxv,
                                 input logic pol,
                                 input logic center);
    logic lv;
    // start level then flip at duty
    lv = center ? (cnt < dty) : (cnt <= dty);
    if (dty == maxv) begin
      lv = 1'b0;
    end
    // duty counts low or high time
    return lv ? pol : ~pol;
  endfunction

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      nx[k] = step({8'h00, cnt_q[k]}, {8'h00, period[k]}, down_q[k],
                   cfg.center);
    end
    // low byte carries into high byte
    nxp = step({cnt_q[0], cnt_q[1]}, {period[0], period[1]}, down_q[0],
               cfg.center);
  end

  always_comb begin
    rollover = 2'b00;
    if (cfg.concat) begin
      rollover = {2{enable[0] & tick[1] & nxp[17]}};
    end else begin
      for (int k = 0; k < 2; k++) begin
        rollover[k] = enable[k] & tick[k] & nx[k][17];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      down_q <= 2'b00;
    end else if (cfg.concat) begin
      if (|clear) begin
        cnt_q <= '0;
        down_q <= 2'b00;
      end else if (enable[0] && tick[1]) begin
        cnt_q[0] <= nxp[15:8];
        cnt_q[1] <= nxp[7:0];
        down_q <= {2{nxp[16]}};
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (clear[k]) begin
          cnt_q[k] <= RST_BYTE;
          down_q[k] <= 1'b0;
        end else if (enable[k] && tick[k]) begin
          cnt_q[k] <= nx[k][7:0];
          down_q[k] <= nx[k][16];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_q <= 2'b00;
    end else if (cfg.concat) begin
      wave_q[0] <= enable[0] ?
        level({cnt_q[0], cnt_q[1]}, {duty[0], duty[1]}, 16'hFFFF,
              polarity[0], cfg.center) : polarity[0];
      wave_q[1] <= polarity[1];
    end else begin
      for (int k = 0; k < 2; k++) begin
        wave_q[k] <= enable[k] ?
          level({8'h00, cnt_q[k]}, {8'h00, duty[k]}, 16'h00FF,
                polarity[k], cfg.center) : polarity[k];
      end
    end
  end

  assign count = cnt_q;
  assign wave = wave_q;

endmodule

// ---- rtl/pwm_top.sv ----
// Four channel PWM with AHB-Lite registers and shared port pins
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module pwm_top
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Port pins
  input wire logic [NCH-1:0] pin_in,
  output logic [NCH-1:0] pin_out,
  output logic [NCH-1:0] pin_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pwm_aphase_s aph_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [7:0] clk_concat_q;
  logic [7:0] sel_pol_q;
  logic [NCH-1:0] enable_q;
  logic center_q;
  logic [7:0] scale0_q;
  logic [7:0] scale1_q;
  logic [NCH-1:0] gpio_dir_q;
  logic [NCH-1:0] gpio_data_q;
  logic [NCH-1:0][7:0] per_buf_q;
  logic [NCH-1:0][7:0] per_act_q;
  logic [NCH-1:0][7:0] dty_buf_q;
  logic [NCH-1:0][7:0] dty_act_q;
  logic [NCH-1:0][7:0] per_buf_d;
  logic [NCH-1:0][7:0] dty_buf_d;
  logic [NCH-1:0][7:0] cnt_w;
  logic [6:0] presc_q;
  logic [NCH-1:0] pin_out_q;
  logic [NCH-1:0] pin_oe_q;
  logic take;
  logic [7:0] wdata8;
  logic [7:0] rd8;
  logic [NCH-1:0] wr_cnt;
  logic [NCH-1:0] wr_per;
  logic [NCH-1:0] wr_dty;
  logic wr_scale0;
  logic wr_scale1;
  logic concat_upper_pair;
  logic concat_lower_pair;
  logic [2:0] prescale_a_code;
  logic [2:0] prescale_b_code;
  logic [NCH-1:0] clk_sel;
  logic [NCH-1:0] polarity;
  logic [NCH-1:0] en_eff;
  logic [NCH-1:0] clr_eff;
  logic [NCH-1:0] latch;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] roll;
  logic [NCH-1:0] wave;
  logic [NCH-1:0] pwm_pin;
  logic tick_a;
  logic tick_b;
  logic tick_s_lo;
  logic tick_s_hi;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_reg(input logic [7:0] a,
                                  input logic [7:0] base);
    return a[7:2] == base[7:2];
  endfunction

  function automatic logic is_grp(input logic [7:0] a,
                                  input logic [7:0] base);
    return a[7:4] == base[7:4];
  endfunction

  function automatic logic presc_tick(input logic [6:0] cnt,
                                      input logic [2:0] code);
    logic [6:0] mask;
    mask = 7'((8'h01 << code) - 8'h01);
    return (cnt & mask) == mask;
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign take = hsel & htrans[1] & hready;
  assign wdata8 = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= '0;
      hreadyout_q <= 1'b1;
      hresp_q <= HRESP_OKAY;
    end else begin
      aph_q.wr <= take & hwrite;
      aph_q.addr <= haddr[7:0];
      hreadyout_q <= 1'b1;
      hresp_q <= HRESP_OKAY;
    end
  end

  always_comb begin
    rd8 = RST_BYTE;
    if (is_reg(haddr[7:0], OFF_CLK_CONCAT)) begin
      rd8 = clk_concat_q;
    end else if (is_reg(haddr[7:0], OFF_CLK_SEL_POL)) begin
      rd8 = sel_pol_q;
    end else if (is_reg(haddr[7:0], OFF_ENABLE)) begin
      rd8 = {RST_NIBBLE, enable_q};
    end else if (is_reg(haddr[7:0], OFF_CTRL)) begin
      rd8 = {7'h00, center_q};
    end else if (is_reg(haddr[7:0], OFF_SCALE0)) begin
      rd8 = scale0_q;
    end else if (is_reg(haddr[7:0], OFF_SCALE1)) begin
      rd8 = scale1_q;
    end else if (is_reg(haddr[7:0], OFF_GPIO_DIR)) begin
      rd8 = {RST_NIBBLE, gpio_dir_q};
    end else if (is_reg(haddr[7:0], OFF_GPIO_DATA)) begin
      rd8 = {RST_NIBBLE, pin_in};
    end else if (is_grp(haddr[7:0], OFF_COUNTER)) begin
      rd8 = cnt_w[haddr[3:2]];
    end else if (is_grp(haddr[7:0], OFF_PERIOD)) begin
      rd8 = per_buf_q[haddr[3:2]];
    end else if (is_grp(haddr[7:0], OFF_DUTY)) begin
      rd8 = dty_buf_q[haddr[3:2]];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= RST_WORD;
    end else if (take && !hwrite) begin
      hrdata_q <= {24'h000000, rd8};
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // writable at any time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_concat_q <= RST_BYTE;
      sel_pol_q <= RST_BYTE;
      enable_q <= RST_NIBBLE;
      center_q <= 1'b0;
      scale0_q <= RST_BYTE;
      scale1_q <= RST_BYTE;
      gpio_dir_q <= RST_NIBBLE;
      gpio_data_q <= RST_NIBBLE;
    end else if (aph_q.wr) begin
      if (is_reg(aph_q.addr, OFF_CLK_CONCAT)) begin
        clk_concat_q <= wdata8;
      end
      if (is_reg(aph_q.addr, OFF_CLK_SEL_POL)) begin
        sel_pol_q <= wdata8;
      end
      if (is_reg(aph_q.addr, OFF_ENABLE)) begin
        enable_q <= wdata8[NCH-1:0];
      end
      if (is_reg(aph_q.addr, OFF_CTRL)) begin
        center_q <= wdata8[BIT_CENTER];
      end
      if (wr_scale0) begin
        scale0_q <= wdata8;
      end
      if (wr_scale1) begin
        scale1_q <= wdata8;
      end
      if (is_reg(aph_q.addr, OFF_GPIO_DIR)) begin
        gpio_dir_q <= wdata8[NCH-1:0];
      end
      if (is_reg(aph_q.addr, OFF_GPIO_DATA)) begin
        gpio_data_q <= wdata8[NCH-1:0];
      end
    end
  end

  assign wr_scale0 = aph_q.wr & is_reg(aph_q.addr, OFF_SCALE0);
  assign wr_scale1 = aph_q.wr & is_reg(aph_q.addr, OFF_SCALE1);
  assign concat_upper_pair = clk_concat_q[BIT_CONCAT_UPPER];
  assign concat_lower_pair = clk_concat_q[BIT_CONCAT_LOWER];
  assign prescale_a_code = clk_concat_q[POS_PRESCALE_A +: 3];
  assign prescale_b_code = clk_concat_q[POS_PRESCALE_B +: 3];
  assign clk_sel = sel_pol_q[POS_CLK_SEL +: NCH];
  assign polarity = sel_pol_q[POS_POLARITY +: NCH];

  // ----------------------------------------------------------------
  // Channel write strobes and pairing
  // ----------------------------------------------------------------
  always_comb begin
    wr_cnt = '0;
    wr_per = '0;
    wr_dty = '0;
    if (aph_q.wr && is_grp(aph_q.addr, OFF_COUNTER)) begin
      wr_cnt[aph_q.addr[3:2]] = 1'b1;
    end
    if (aph_q.wr && is_grp(aph_q.addr, OFF_PERIOD)) begin
      wr_per[aph_q.addr[3:2]] = 1'b1;
    end
    if (aph_q.wr && is_grp(aph_q.addr, OFF_DUTY)) begin
      wr_dty[aph_q.addr[3:2]] = 1'b1;
    end
  end

  always_comb begin
    en_eff = enable_q;
    clr_eff = wr_cnt;
    // lower pair follows channel 0 enable
    if (concat_lower_pair) begin
      en_eff[1] = enable_q[0];
      clr_eff[1:0] = {2{|wr_cnt[1:0]}};
    end
    // upper pair follows channel 2 enable
    if (concat_upper_pair) begin
      en_eff[3] = enable_q[2];
      clr_eff[3:2] = {2{|wr_cnt[3:2]}};
    end
  end

  // ----------------------------------------------------------------
  // Double buffered period and duty
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign per_buf_d[c] = wr_per[c] ? wdata8 : per_buf_q[c];
    assign dty_buf_d[c] = wr_dty[c] ? wdata8 : dty_buf_q[c];
    // latch on disable, rollover or counter write
    assign latch[c] = ~en_eff[c] | roll[c] | clr_eff[c];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        per_buf_q[c] <= RST_BYTE;
        dty_buf_q[c] <= RST_BYTE;
        per_act_q[c] <= RST_BYTE;
        dty_act_q[c] <= RST_BYTE;
      end else begin
        per_buf_q[c] <= per_buf_d[c];
        dty_buf_q[c] <= dty_buf_d[c];
        if (latch[c]) begin
          per_act_q[c] <= per_buf_d[c];
          dty_act_q[c] <= dty_buf_d[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_q <= RST_PRESCALE;
    end else if (|enable_q) begin
      presc_q <= presc_q + 7'h01;
    end else begin
      presc_q <= RST_PRESCALE;
    end
  end

  // clock A divide by two to the code
  assign tick_a = presc_tick(presc_q, prescale_a_code);
  assign tick_b = presc_tick(presc_q, prescale_b_code);

  pwm_scaler #(
    .W(8)
  ) u_scaled_clock_lower (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick_in(tick_a),
    .load(wr_scale0),
    .scale(wr_scale0 ? wdata8 : scale0_q),
    .tick_out(tick_s_lo)
  );

  pwm_scaler #(
    .W(8)
  ) u_scaled_clock_upper (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick_in(tick_b),
    .load(wr_scale1),
    .scale(wr_scale1 ? wdata8 : scale1_q),
    .tick_out(tick_s_hi)
  );

  always_comb begin
    tick[0] = clk_sel[0] ? tick_s_lo : tick_a;
    tick[1] = clk_sel[1] ? tick_s_lo : tick_a;
    tick[2] = clk_sel[2] ? tick_s_hi : tick_b;
    tick[3] = clk_sel[3] ? tick_s_hi : tick_b;
  end

  // ----------------------------------------------------------------
  // Channel pairs
  // ----------------------------------------------------------------
  // two pairs of 8-bit channels
  for (genvar p = 0; p < NPAIR; p++) begin : g_pair
    pwm_pair_cfg_s cfg;
    assign cfg.concat = (p == 0) ? concat_lower_pair : concat_upper_pair;
    assign cfg.center = center_q;

    pwm_pair u_pair (
      .hclk(hclk),
      .hresetn(hresetn),
      .cfg(cfg),
      .enable(en_eff[2*p +: 2]),
      .polarity(polarity[2*p +: 2]),
      .tick(tick[2*p +: 2]),
      .clear(clr_eff[2*p +: 2]),
      .period(per_act_q[2*p +: 2]),
      .duty(dty_act_q[2*p +: 2]),
      .count(cnt_w[2*p +: 2]),
      .rollover(roll[2*p +: 2]),
      .wave(wave[2*p +: 2])
    );
  end

  // ----------------------------------------------------------------
  // Port pins
  // ----------------------------------------------------------------
  // low byte pin stays general purpose
  assign pwm_pin = enable_q &
    ~{concat_upper_pair, 1'b0, concat_lower_pair, 1'b0};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_q <= RST_NIBBLE;
      pin_oe_q <= RST_NIBBLE;
    end else begin
      pin_out_q <= (pwm_pin & wave) | (~pwm_pin & gpio_data_q);
      pin_oe_q <= gpio_dir_q | enable_q;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;

endmodule

// ---- verification/pwm_pin_load.sv ----
// Load on the shared port pins
`timescale 1ns/100ps
module pwm_pin_load
  import pwm_pkg::*;
(
  // Module side
  input wire logic [NCH-1:0] pin_out,
  input wire logic [NCH-1:0] pin_oe,
  // Load drive on released pins
  input wire logic [NCH-1:0] ext_val,
  // Resolved level
  output logic [NCH-1:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// ---- verification/pwm_top_assertions.sv ----
// Checker of bus answers and pin drive
`timescale 1ns/100ps
module pwm_top_checker
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic [NCH-1:0] pin_out,
  input wire logic [NCH-1:0] pin_oe
);
  logic ap_q, wr_q, rd;
  logic [7:0] ad_q;
  logic [7:0] sh_q [8];
  logic [3:0] en, dir, dat;
  assign rd = ap_q && !wr_q;
  assign en = sh_q[2][3:0];
  assign dir = sh_q[6][3:0];
  assign dat = sh_q[7][3:0];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // --------------------------------
  // Data phase and register shadow
  // --------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      wr_q <= 1'b0;
      ad_q <= 8'h00;
    end else begin
      ap_q <= hsel && htrans[1] && hready;
      wr_q <= hwrite;
      ad_q <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      sh_q <= '{default: 8'h00};
    else if (ap_q && wr_q && ad_q[7:5] == 3'h0)
      sh_q[ad_q[4:2]] <= hwdata[7:0];
  end
  property p_ready; hreadyout; endproperty
  property p_okay; hresp == HRESP_OKAY; endproperty
  property p_rd_clk;
    rd && ad_q == OFF_CLK_CONCAT |-> hrdata == {24'h0, sh_q[0]};
  endproperty
  property p_rd_pol;
    rd && ad_q == OFF_CLK_SEL_POL |-> hrdata == {24'h0, sh_q[1]};
  endproperty
  property p_rd_none; rd && ad_q >= 8'h50 |-> hrdata == 32'h0; endproperty
  property p_oe_en; $stable(en) |-> (en & ~pin_oe) == 4'h0; endproperty
  property p_oe_dir; $stable(en | dir) |-> pin_oe == (en | dir); endproperty
  property p_gpio;
    $stable({en, dir, dat}) |-> ((pin_out ^ dat) & ~en & dir) == 4'h0;
  endproperty
  a_ready: assert property (p_ready)
    else $error("hreadyout low");
  a_okay: assert property (p_okay)
    else $error("hresp not okay");
  a_rd_clk: assert property (p_rd_clk)
    else $error("clock register read wrong");
  a_rd_pol: assert property (p_rd_pol)
    else $error("polarity register read wrong");
  a_rd_none: assert property (p_rd_none)
    else $error("unmapped read not zero");
  a_oe_en: assert property (p_oe_en)
    else $error("enabled pin not driven");
  a_oe_dir: assert property (p_oe_dir)
    else $error("pin enable wrong");
  a_gpio: assert property (p_gpio)
    else $error("port data not on pin");
  c_wr_en: cover property (ap_q && wr_q && ad_q == OFF_ENABLE);
  c_rd_pol: cover property (rd && ad_q == OFF_CLK_SEL_POL);
  c_oe_all: cover property (pin_oe == 4'hF);
endmodule
bind pwm_top pwm_top_checker i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pin_out(pin_out), .pin_oe(pin_oe)
);

// ---- verification/test_pwm_top.sv ----
// Self-checking bench of the PWM block
`timescale 1ns/100ps
module test_pwm_top
  import pwm_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [31:0] hrdata, rd, v;
  logic hreadyout, hresp;
  logic [NCH-1:0] pin_in, pin_out, pin_oe;
  logic [NCH-1:0] ext_val = 4'h0;
  logic [31:0] seed = 32'h7BBB;
  int n_fail = 0;
  int tests_run = 0;
  always #50 hclk = ~hclk;
  pwm_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
  );
  pwm_pin_load i_load (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_ones(int p, int d, logic pol, int div,
                                  logic ctr);
    int n;
    if (!ctr) begin
      if (d == 255)
        return pol ? 0 : (p + 1) * div;
      return (pol ? d + 1 : p - d) * div;
    end
    if (d == 255)
      return pol ? 0 : 2 * p * div;
    n = (d == 0) ? 0 : 2 * d - 1;
    return (pol ? n : 2 * p - n) * div;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdx(logic [7:0] a);
    ahb(1'b0, a, 32'h0);
  endtask
  task automatic meas(int ch, int n, output int ones);
    ones = 0;
    repeat (n) begin
      @(posedge hclk);
      ones += (pin_out[ch] === 1'b1);
    end
  endtask
  task automatic run_ch(int ch, logic [2:0] c, logic s, logic [7:0] sc,
                        int p, int d, logic pol, logic ctr = 1'b0);
    int div, n, w, e;
    logic [7:0] o;
    div = (1 << c) * (s ? 2 * (sc + 1) : 1);
    w = ctr ? 2 * p * div : (p + 1) * div;
    o = 8'(4 * ch);
    wr(OFF_ENABLE, 32'h0);
    wr(OFF_CTRL, 32'(ctr));
    // clock select changed only while disabled
    wr(OFF_CLK_CONCAT, ch < 2 ? {c, 3'h0} : c);
    wr(OFF_CLK_SEL_POL, (32'(s) << (4 + ch)) | (32'(pol) << ch));
    wr(ch < 2 ? OFF_SCALE0 : OFF_SCALE1, sc);
    wr(OFF_PERIOD + o, p);
    wr(OFF_DUTY + o, ~d);
    rdx(OFF_PERIOD + o);
    chk("period", p, rd);
    wr(OFF_ENABLE, 32'h1 << ch);
    wr(OFF_DUTY + o, d);
    wr(OFF_COUNTER + o, 32'h0);
    rdx(OFF_COUNTER + o);
    chk("count_clr", 1, rd <= 1);
    repeat (w + div) @(posedge hclk);
    meas(ch, w, n);
    e = exp_ones(p, d, pol, div, ctr);
    chk("ones", e, n);
    rdx(OFF_COUNTER + o);
    chk("count", 1, rd <= p);
  endtask
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #3ms;
    n_fail++;
    end_sim();
  end
  initial begin
    int n;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdx(OFF_CLK_SEL_POL);
    chk("reset", 32'h0, rd);
    repeat (4) begin
      v = rnd();
      wr(OFF_CLK_CONCAT, v[7:0]);
      wr(OFF_CLK_SEL_POL, v[31:24]);
      rdx(OFF_CLK_CONCAT);
      chk("clk_reg", v[7:0], rd);
      rdx(OFF_CLK_SEL_POL);
      chk("pol_reg", v[31:24], rd);
    end
    rdx(8'h50);
    chk("unmapped", 32'h0, rd);
    wr(OFF_ENABLE, 32'h0);
    ext_val <= v[3:0];
    wr(OFF_GPIO_DATA, ~v);
    rdx(OFF_GPIO_DATA);
    chk("pin_in", v[3:0], rd);
    wr(OFF_GPIO_DIR, 32'hF);
    repeat (2) @(posedge hclk);
    chk("oe", 32'hF, pin_oe);
    rdx(OFF_GPIO_DATA);
    chk("pin_back", {28'h0, ~v[3:0]}, rd);
    for (int k = 0; k < 8; k++) begin
      v = rnd();
      run_ch(k % 4, 3'(v[6:5] % 3), k[2], v[8], 2 + v[1:0],
             v[4:2] % (2 + v[1:0]), v[9]);
    end
    run_ch(1, 3'h1, 1'b0, 8'h0, 4, 3, 1'b1, 1'b1);
    run_ch(2, 3'h0, 1'b1, 8'h1, 3, 1, 1'b0, 1'b1);
    run_ch(0, 3'h0, 1'b0, 8'h0, 3, 255, 1'b1);
    run_ch(3, 3'h1, 1'b1, 8'h0, 3, 255, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_ENABLE, 32'h0);
      wr(OFF_CLK_CONCAT, k ? 32'h80 : 32'h40);
      wr(OFF_CLK_SEL_POL, 32'h3 << (2 * k));
      wr(OFF_PERIOD + 8'(8 * k), 32'h1);
      wr(OFF_PERIOD + 8'(8 * k + 4), 32'h3);
      wr(OFF_DUTY + 8'(8 * k), 32'h0);
      wr(OFF_DUTY + 8'(8 * k + 4), 32'h80);
      wr(OFF_COUNTER + 8'(8 * k), 32'h0);
      wr(OFF_ENABLE, 32'h3 << (2 * k));
      repeat (262) @(posedge hclk);
      meas(2 * k, 260, n);
      chk("concat", 129, n);
    end
    end_sim();
  end
endmodule
